// file: core/pbps_sequencer.sv
// Push button power sequencer: debounce, blanking, power-down request and forced release.
`timescale 1ns/10ps
`include "pbps_params.svh"
// ======================================================================
// Summary of operation
// - Enable only after button held low for the full turn-on debounce time.
// - Enable asserting starts a fixed blanking timer for the host.
// - Power-off still low at blanking end releases enable at once.
// - Only the button can turn power on.
// - Enable polarity is a build-time parameter.
// - While on, button or undervoltage low for debounce time asserts request.
// - First source low owns the sequence; other ignored until owner releases and any request it raised ends.
// - Owner low for minimum plus extra delay forces enable release.
// - After blanking, power-off low releases enable regardless of request.
// - Power fail output follows comparator, independent of sequencing.
// - While off and undervoltage present, the button is ignored.
// - Request lasts at least debounce length and while the owning source stays low.
// - Forced off releases request and enable together.
// - Extra delay counts cycles of a separate adjustable-period timer.
module pbps_sequencer #(
  parameter bit                       EN_ACTIVE_HIGH = 1'b1,
  parameter logic [`PBPS_CNT_W-1:0]   ON_DB_CYC      = `PBPS_CNT_W'(`PBPS_ON_DB_CYC),
  parameter logic [`PBPS_CNT_W-1:0]   OFF_DB_CYC     = `PBPS_CNT_W'(`PBPS_OFF_DB_CYC),
  parameter logic [`PBPS_CNT_W-1:0]   BLANK_CYC      = `PBPS_CNT_W'(`PBPS_BLANK_CYC),
  parameter logic [`PBPS_CNT_W-1:0]   MIN_PD_CYC     = `PBPS_CNT_W'(`PBPS_MIN_PD_CYC),
  parameter logic [`PBPS_CNT_W-1:0]   EXTRA_TICK_CYC = `PBPS_CNT_W'(`PBPS_EXTRA_TICK_CYC),
  parameter logic [`PBPS_EXT_W-1:0]   EXTRA_CYCLES   = `PBPS_EXT_W'(`PBPS_EXTRA_CYCLES)
) (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic push_button_n,
  input  wire logic undervoltage_compare_in,
  input  wire logic power_off_n,
  input  wire logic power_fail_compare_in,
  output logic      powerEnable,
  output logic      powerDownReq_n,
  output logic      powerDownReqOe,
  output logic      power_fail_flag_n,
  output logic      powerFailOe
);
  pbps_pkg::pbps_pins_t  pins;
  pbps_pkg::pbps_state_t state_q, state_d;
  pbps_pkg::pbps_owner_t owner_q, owner_d;
  logic [`PBPS_CNT_W-1:0] onCnt_q, onCnt_d;
  logic [`PBPS_CNT_W-1:0] blankCnt_q, blankCnt_d;
  logic [`PBPS_CNT_W-1:0] ownCnt_q, ownCnt_d;
  logic [`PBPS_CNT_W-1:0] tick_q, tick_d;
  logic [`PBPS_EXT_W-1:0] extCnt_q, extCnt_d;
  logic                   req_q, req_d;
  logic                   enOn_q, enOn_d;
  logic                   pfLow_q, pfLow_d;
  logic                   btnLow, uvLow, ownerLow, forceOff;

  function automatic logic [`PBPS_CNT_W-1:0] satInc(input logic [`PBPS_CNT_W-1:0] v);
    satInc = (v == '1) ? v : v + `PBPS_CNT_W'(1);
  endfunction : satInc

  pbps_sync u_sync (
    .ref_clk (ref_clk),
    .srst    (srst),
    .pinsIn  ({push_button_n, undervoltage_compare_in, power_off_n, power_fail_compare_in}),
    .pinsOut (pins)
  );

  assign btnLow   = ~pins.button;
  assign uvLow    = ~pins.underVolt;
  assign ownerLow = (owner_q == pbps_pkg::PBPS_OWN_BTN) ? btnLow :
                    (owner_q == pbps_pkg::PBPS_OWN_UV) ? uvLow : 1'b0;
  assign forceOff = ownerLow && (ownCnt_q >= MIN_PD_CYC) && (extCnt_q >= EXTRA_CYCLES);

  // ======================================================================
  // Sequencer next state
  always_comb begin
    state_d    = state_q;
    owner_d    = owner_q;
    onCnt_d    = '0;
    blankCnt_d = '0;
    ownCnt_d   = '0;
    tick_d     = '0;
    extCnt_d   = '0;
    req_d      = 1'b0;
    enOn_d     = enOn_q;
    case (state_q)
      pbps_pkg::PBPS_OFF: begin
        owner_d = pbps_pkg::PBPS_OWN_NONE;
        if (btnLow && !uvLow) begin
          onCnt_d = satInc(onCnt_q);
        end
        if (btnLow && !uvLow && onCnt_q >= ON_DB_CYC - `PBPS_CNT_W'(1)) begin
          state_d = pbps_pkg::PBPS_BLANK;
          enOn_d  = 1'b1;
        end
      end
      pbps_pkg::PBPS_BLANK: begin
        blankCnt_d = satInc(blankCnt_q);
        if (pins.powerOff) begin
          state_d = pbps_pkg::PBPS_RUN;
        end else if (blankCnt_q >= BLANK_CYC - `PBPS_CNT_W'(1)) begin
          state_d = pbps_pkg::PBPS_OFF;
          enOn_d  = 1'b0;
        end
      end
      pbps_pkg::PBPS_RUN: begin
        if (owner_q == pbps_pkg::PBPS_OWN_NONE) begin
          if (btnLow) begin
            owner_d = pbps_pkg::PBPS_OWN_BTN;
          end else if (uvLow) begin
            owner_d = pbps_pkg::PBPS_OWN_UV;
          end
        end else if (ownerLow) begin
          ownCnt_d = satInc(ownCnt_q);
          if (ownCnt_q >= MIN_PD_CYC) begin
            tick_d = (tick_q >= EXTRA_TICK_CYC - `PBPS_CNT_W'(1)) ? '0 : tick_q + `PBPS_CNT_W'(1);
            extCnt_d = (tick_q >= EXTRA_TICK_CYC - `PBPS_CNT_W'(1) && extCnt_q != '1) ?
                       extCnt_q + `PBPS_EXT_W'(1) : extCnt_q;
          end
        end else if (!req_q) begin
          owner_d = pbps_pkg::PBPS_OWN_NONE;
        end else begin
          ownCnt_d = satInc(ownCnt_q);
        end
        // request minimum width and hold
        // The count keeps running after the source lets go, so a second debounce length gives the minimum width.
        req_d = req_q ? (ownerLow || ownCnt_q < (OFF_DB_CYC << 1) - `PBPS_CNT_W'(1)) :
                (ownerLow && ownCnt_q >= OFF_DB_CYC - `PBPS_CNT_W'(1));
        if (!req_d && req_q && !ownerLow) begin
          owner_d  = pbps_pkg::PBPS_OWN_NONE;
          ownCnt_d = '0;
        end
        if (!pins.powerOff || forceOff) begin
          state_d = pbps_pkg::PBPS_OFF;
          owner_d = pbps_pkg::PBPS_OWN_NONE;
          enOn_d  = 1'b0;
          req_d   = 1'b0;
        end
      end
      default: begin
        state_d = pbps_pkg::PBPS_OFF;
        enOn_d  = 1'b0;
      end
    endcase
    pfLow_d = ~pins.powerFail;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q    <= pbps_pkg::PBPS_OFF;
      owner_q    <= pbps_pkg::PBPS_OWN_NONE;
      onCnt_q    <= '0;
      blankCnt_q <= '0;
      ownCnt_q   <= '0;
      tick_q     <= '0;
      extCnt_q   <= '0;
      req_q      <= 1'b0;
      enOn_q     <= 1'b0;
      pfLow_q    <= 1'b0;
    end else begin
      state_q    <= state_d;
      owner_q    <= owner_d;
      onCnt_q    <= onCnt_d;
      blankCnt_q <= blankCnt_d;
      ownCnt_q   <= ownCnt_d;
      tick_q     <= tick_d;
      extCnt_q   <= extCnt_d;
      req_q      <= req_d;
      enOn_q     <= enOn_d;
      pfLow_q    <= pfLow_d;
    end
  end

  // ======================================================================
  // Outputs
  // enable polarity option
  assign powerEnable       = EN_ACTIVE_HIGH ? enOn_q : ~enOn_q;
  assign powerDownReq_n    = ~req_q;
  assign powerDownReqOe    = req_q;
  assign power_fail_flag_n = ~pfLow_q;
  assign powerFailOe       = pfLow_q;

  // ======================================================================
  // Checks
  a_on_needs_button: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(enOn_q) |-> $past(btnLow) && $past(state_q) == pbps_pkg::PBPS_OFF) else $error("Enable rose without button.");
  a_lockout_holds: assert property (@(posedge ref_clk) disable iff (srst)
    (state_q == pbps_pkg::PBPS_OFF && uvLow) |=> !enOn_q) else $error("Enable rose under lockout.");
  a_blank_abort: assert property (@(posedge ref_clk) disable iff (srst)
    (state_q == pbps_pkg::PBPS_BLANK && !pins.powerOff && blankCnt_q >= BLANK_CYC - 1) |=> !enOn_q)
    else $error("Blanking end did not release enable.");
  a_blank_start: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(enOn_q) |-> state_q == pbps_pkg::PBPS_BLANK && blankCnt_q == 0) else $error("Blanking did not start.");
  a_host_kill: assert property (@(posedge ref_clk) disable iff (srst)
    (state_q == pbps_pkg::PBPS_RUN && !pins.powerOff) |=> !enOn_q) else $error("Power-off low ignored.");
  a_force_both: assert property (@(posedge ref_clk) disable iff (srst)
    (state_q == pbps_pkg::PBPS_RUN && forceOff) |=> !enOn_q && !req_q) else $error("Forced off not simultaneous.");
  a_req_hold: assert property (@(posedge ref_clk) disable iff (srst)
    (req_q && ownerLow && enOn_q && pins.powerOff && !forceOff) |=> req_q) else $error("Request dropped early.");
  a_req_only_on: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(req_q) |-> state_q == pbps_pkg::PBPS_RUN && $past(ownerLow)) else $error("Request without source.");
  a_pf_follow: assert property (@(posedge ref_clk) disable iff (srst)
    ##1 power_fail_flag_n == $past(pins.powerFail)) else $error("Power fail flag wrong.");
  a_reset_off: assert property (@(posedge ref_clk)
    $past(srst) |-> !enOn_q && !req_q) else $error("Not off after reset.");
endmodule : pbps_sequencer

// file: core/pbps_params.svh
// Timing counts and option defaults for the push button power sequencer.
`ifndef PBPS_PARAMS_SVH
`define PBPS_PARAMS_SVH
// ======================================================================
// Timing
`define PBPS_CLK_PERIOD_NS   10
`define PBPS_ON_DB_MS        32
`define PBPS_OFF_DB_MS       32
`define PBPS_BLANK_MS        512
`define PBPS_MIN_PD_MS       64
`define PBPS_EXTRA_CYCLES    16
`define PBPS_MS_TO_CYC(ms)   (((ms) * 1000000) / `PBPS_CLK_PERIOD_NS)
`define PBPS_ON_DB_CYC       `PBPS_MS_TO_CYC(`PBPS_ON_DB_MS)
`define PBPS_OFF_DB_CYC      `PBPS_MS_TO_CYC(`PBPS_OFF_DB_MS)
`define PBPS_BLANK_CYC       `PBPS_MS_TO_CYC(`PBPS_BLANK_MS)
`define PBPS_MIN_PD_CYC      `PBPS_MS_TO_CYC(`PBPS_MIN_PD_MS)
`define PBPS_EXTRA_TICK_CYC  1000000
`define PBPS_CNT_W           32
`define PBPS_EXT_W           8
`endif

// file: core/pbps_pkg.sv
// Types for the push button power sequencer.
package pbps_pkg;
  // ======================================================================
  // Sequencer states
  typedef enum logic [1:0] {
    PBPS_OFF   = 2'b00,
    PBPS_BLANK = 2'b01,
    PBPS_RUN   = 2'b10
  } pbps_state_t;

  // ======================================================================
  // Owner of a power-down sequence
  typedef enum logic [1:0] {
    PBPS_OWN_NONE = 2'b00,
    PBPS_OWN_BTN  = 2'b01,
    PBPS_OWN_UV   = 2'b10
  } pbps_owner_t;

  // ======================================================================
  // Synchronised pin levels, all low when the condition is present
  typedef struct packed {
    logic button;
    logic underVolt;
    logic powerOff;
    logic powerFail;
  } pbps_pins_t;
endpackage : pbps_pkg

// file: core/pbps_sync.sv
// Two-stage synchroniser for the sequencer's pin group.
`timescale 1ns/10ps
module pbps_sync (
  input  wire logic               ref_clk,
  input  wire logic               srst,
  input  wire pbps_pkg::pbps_pins_t pinsIn,
  output pbps_pkg::pbps_pins_t    pinsOut
);
  pbps_pkg::pbps_pins_t stage1_q;
  pbps_pkg::pbps_pins_t stage1_d;
  pbps_pkg::pbps_pins_t stage2_q;
  pbps_pkg::pbps_pins_t stage2_d;

  // ======================================================================
  // Synchroniser
  // Reset to the idle level so no false press is seen after reset.
  always_comb begin
    stage1_d = pinsIn;
    stage2_d = stage1_q;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stage1_q <= 4'hf;
      stage2_q <= 4'hf;
    end else begin
      stage1_q <= stage1_d;
      stage2_q <= stage2_d;
    end
  end

  assign pinsOut = stage2_q;
endmodule : pbps_sync

// file: tb/pbps_host_model.sv
// Behavioural host that answers the blanking window and the power down request.
`timescale 1ns/10ps
module pbps_host_model (
  input  wire logic ref_clk,
  input  wire logic hostPowered,
  input  wire logic requestWire,
  input  wire logic respond,
  input  wire logic obey,
  output logic      power_off_n
);
  int bootCnt;
  int jobCnt;
  // An unpowered host cannot hold the line, so it reads as a kill.
  initial power_off_n = 1'b0;
  // ======================================================================
  // Host behaviour
  always @(posedge ref_clk) begin
    if (!hostPowered) begin
      bootCnt <= 0;
      jobCnt <= 0;
      power_off_n <= 1'b0;
    end else begin
      if (bootCnt < 5) bootCnt <= bootCnt + 1;
      if (!requestWire || jobCnt > 0) jobCnt <= jobCnt + 1;
      if (!respond) power_off_n <= 1'b0;
      else if (obey && jobCnt >= 4) power_off_n <= 1'b0;
      else if (bootCnt >= 4) power_off_n <= 1'b1;
    end
  end
endmodule : pbps_host_model

// file: tb/pbps_sequencer_bench.sv
// Self-checking bench for the push button power sequencer.
`timescale 1ns/10ps
module pbps_sequencer_bench;
  logic ref_clk = 1'b0;
  logic srst    = 1'b1;
  logic btnN    = 1'b1;
  logic uvIn    = 1'b1;
  logic pfIn    = 1'b1;
  logic respond = 1'b1;
  logic obey    = 1'b0;
  logic powerOffN;
  logic powerEnable;
  logic reqN;
  logic reqOe;
  logic pfN;
  logic pfOe;
  int   fails = 0;
  int   comparisons = 0;
  // Open-drain pins with pull-ups.
  wire  reqWire = reqOe ? 1'b0 : 1'b1;
  wire  pfWire  = pfOe ? 1'b0 : 1'b1;

  initial forever #5 ref_clk = ~ref_clk;

  // Counts shortened: forced off at 16 + 16 * 4 owner-low cycles; polarity and extra count keep their defaults.
  pbps_sequencer #(.ON_DB_CYC(32'h8), .OFF_DB_CYC(32'h8), .BLANK_CYC(32'h28),
    .MIN_PD_CYC(32'h10), .EXTRA_TICK_CYC(32'h4)) dut (
    .ref_clk(ref_clk), .srst(srst), .push_button_n(btnN), .undervoltage_compare_in(uvIn),
    .power_off_n(powerOffN), .power_fail_compare_in(pfIn), .powerEnable(powerEnable),
    .powerDownReq_n(reqN), .powerDownReqOe(reqOe), .power_fail_flag_n(pfN), .powerFailOe(pfOe));

  pbps_host_model host (.ref_clk(ref_clk), .hostPowered(powerEnable), .requestWire(reqWire),
    .respond(respond), .obey(obey), .power_off_n(powerOffN));

  // ======================================================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick
  task automatic chk(input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Bounded wait on enable (which 0) or the request wire (which 1).
  task automatic waitSig(input int which, input logic lvl, input int maxc);
    int i;
    i = 0;
    while ((((which == 0) ? powerEnable : reqWire) !== lvl) && i < maxc) begin
      tick(1);
      i++;
    end
  endtask : waitSig
  task automatic press(input int n);
    btnN = 1'b0;
    tick(n);
    btnN = 1'b1;
  endtask : press
  task automatic powerUp;
    press(12);
    waitSig(0, 1'b1, 10);
    chk(powerEnable, 1'b1);
    tick(50);
  endtask : powerUp
  task automatic stop_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  // ======================================================================
  // Scenarios
  task automatic testOffStates;
    chk(powerEnable, 1'b0);
    chk(reqWire, 1'b1);
    uvIn = 1'b0;
    press(20);
    tick(10);
    chk(powerEnable, 1'b0);
    uvIn = 1'b1;
    tick(10);
    chk(powerEnable, 1'b0);
    press(5);
    tick(20);
    chk(powerEnable, 1'b0);
    pfIn = 1'b0;
    tick(4);
    chk(pfWire, 1'b0);
    pfIn = 1'b1;
    tick(4);
    chk(pfWire, 1'b1);
    $display("test off states done");
  endtask : testOffStates
  task automatic testAbort;
    respond = 1'b0;
    press(12);
    waitSig(0, 1'b1, 10);
    tick(30);
    chk(powerEnable, 1'b1);
    waitSig(0, 1'b0, 20);
    chk(powerEnable, 1'b0);
    respond = 1'b1;
    tick(5);
    $display("test abort done");
  endtask : testAbort
  task automatic testRequest;
    powerUp();
    chk(powerEnable, 1'b1);
    btnN = 1'b0;
    tick(6);
    chk(reqWire, 1'b1);
    waitSig(1, 1'b0, 10);
    chk(reqWire, 1'b0);
    tick(30);
    chk(reqWire, 1'b0);
    btnN = 1'b1;
    uvIn = 1'b0;
    waitSig(1, 1'b1, 6);
    chk(reqWire, 1'b1);
    waitSig(1, 1'b0, 15);
    chk(reqWire, 1'b0);
    uvIn = 1'b1;
    obey = 1'b1;
    waitSig(0, 1'b0, 20);
    chk(powerEnable, 1'b0);
    obey = 1'b0;
    tick(5);
    $display("test request done");
  endtask : testRequest
  task automatic testKill;
    powerUp();
    chk(reqWire, 1'b1);
    press(12);
    tick(5);
    chk(reqWire, 1'b0);
    waitSig(1, 1'b1, 10);
    chk(reqWire, 1'b1);
    respond = 1'b0;
    waitSig(0, 1'b0, 6);
    chk(powerEnable, 1'b0);
    respond = 1'b1;
    tick(5);
    $display("test kill done");
  endtask : testKill
  task automatic testForced;
    powerUp();
    btnN = 1'b0;
    tick(75);
    chk(powerEnable, 1'b1);
    waitSig(0, 1'b0, 15);
    chk(powerEnable, 1'b0);
    chk(reqWire, 1'b1);
    btnN = 1'b1;
    tick(10);
    $display("test forced done");
  endtask : testForced
  task automatic testUnderVolt;
    powerUp();
    uvIn = 1'b0;
    waitSig(1, 1'b0, 15);
    chk(reqWire, 1'b0);
    waitSig(0, 1'b0, 90);
    chk(powerEnable, 1'b0);
    chk(reqWire, 1'b1);
    uvIn = 1'b1;
    tick(10);
    $display("test undervoltage done");
  endtask : testUnderVolt

  initial begin
    tick(10);
    srst = 1'b0;
    tick(3);
    testOffStates();
    testAbort();
    testRequest();
    testKill();
    testForced();
    testUnderVolt();
    stop_test();
  end
  // The tests need under a thousand cycles.
  initial begin
    tick(5000);
    fails++;
    stop_test();
  end
endmodule : pbps_sequencer_bench
